/* shared/t2c_defines.svh */
// Offsets, field positions, reset values and timing counts of timer 2.
// Assumes an 8-bit special function register port with byte addresses.
`ifndef T2C_DEFINES_SVH
`define T2C_DEFINES_SVH

// ****************************************
// Register offsets
// ****************************************
`define T2C_ADDR_CH1_LO 8'hc2
`define T2C_ADDR_CH1_HI 8'hc3
`define T2C_ADDR_CH2_LO 8'hc4
`define T2C_ADDR_CH2_HI 8'hc5
`define T2C_ADDR_CH3_LO 8'hc6
`define T2C_ADDR_CH3_HI 8'hc7
`define T2C_ADDR_CTRL 8'hc8
`define T2C_ADDR_MODE_EN 8'hc9
`define T2C_ADDR_RL_LO 8'hca
`define T2C_ADDR_RL_HI 8'hcb
`define T2C_ADDR_CNT_LO 8'hcc
`define T2C_ADDR_CNT_HI 8'hcd

// ****************************************
// Timer control fields
// ****************************************
`define T2C_BIT_PRESCALE 7
`define T2C_BIT_MASTER_DIV 6
`define T2C_BIT_WIDTH 5
`define T2C_BIT_RELOAD_HI 4
`define T2C_BIT_RELOAD_LO 3
`define T2C_BIT_CMP_MODE 2
`define T2C_BIT_INSEL_HI 1
`define T2C_BIT_INSEL_LO 0

// ****************************************
// Reset values and divider counts
// ****************************************
`define T2C_RST_BYTE 8'h00
`define T2C_RST_WORD 16'h0000
`define T2C_DIV_MASTER 5'd2
`define T2C_DIV_SLOW 5'd12
`define T2C_DIV_SLOWER 5'd24

`endif

/* shared/t2c_pkg.sv */
// Types shared by the timer 2 compare/capture/reload unit.
// Assumes the defines header is included by the design files.
package t2c_pkg;

  // ****************************************
  // Enumerations
  // ****************************************
  typedef enum logic [1:0] {
    IN_STOP, IN_INTERNAL, IN_EVENT, IN_GATED
  } t2c_insel_e;

  typedef enum logic [1:0] {
    CH_OFF, CH_CAP_PIN, CH_COMPARE, CH_CAP_WRITE
  } t2c_chmode_e;

endpackage

/* shared/t2c_ch_if.sv */
// Carrier between the timer core and one compare channel.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface t2c_ch_if;
  import t2c_pkg::*;
  logic [15:0] timer;
  logic [15:0] value;
  t2c_chmode_e mode;
  logic cmp_mode;
  logic narrow;
  logic overflow;
  logic latch_wr;
  logic latch_d;
  logic match;
  logic pin;
  logic level;
  modport chan (input timer, value, mode, cmp_mode, narrow, overflow,
    latch_wr, latch_d, output match, pin, level);
  modport core (output timer, value, mode, cmp_mode, narrow, overflow,
    latch_wr, latch_d, input match, pin, level);
endinterface
`default_nettype wire

/* verilog/t2c_channel.sv */
// One compare channel: match detection, compare signal and port output.
// Assumes timer, value and controls come from flops on clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "t2c_defines.svh"
module t2c_channel (
  input wire logic clk_i,
  input wire logic rst_i,
  t2c_ch_if.chan ch
);
  import t2c_pkg::*;

  logic eq_q, latch_q, match_q, pin_q, level_q;
  logic pin_d;
  wire cmp_en = (ch.mode == CH_COMPARE);
  wire [15:0] mask = ch.narrow ? 16'h00ff : 16'hffff;
  wire [15:0] val_m = ch.value & mask;
  wire [15:0] tim_m = ch.timer & mask;
  wire eq = cmp_en && (val_m == tim_m);
  // Only the first cycle of equality counts, a stalled timer repeats none
  wire hit = eq && !eq_q;

  // ****************************************
  // Output level
  // ****************************************
  always_comb begin
    pin_d = pin_q;
    if (!cmp_en) begin
      if (ch.latch_wr) pin_d = ch.latch_d;
    end else if (!ch.cmp_mode) begin
      if (hit) pin_d = 1'b1;
      else if (ch.overflow) pin_d = 1'b0;
    end else if (hit) begin
      pin_d = latch_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      eq_q <= 1'b0;
      latch_q <= 1'b0;
      match_q <= 1'b0;
      pin_q <= 1'b0;
      level_q <= 1'b0;
    end else begin
      eq_q <= eq;
      if (ch.latch_wr) latch_q <= ch.latch_d;
      match_q <= hit;
      pin_q <= pin_d;
      level_q <= cmp_en && (val_m > tim_m);
    end
  end

  assign ch.match = match_q;
  assign ch.pin = pin_q;
  assign ch.level = level_q;
endmodule
`default_nettype wire

/* verilog/t2c_timer2.sv */
// Timer 2 with one reload channel and three ordinary compare/capture
// channels, reached over the special function register port.
// Assumes pins are asynchronous and clk_i is the oscillator clock.
`timescale 1ns/1ps
`default_nettype none
`include "t2c_defines.svh"
module t2c_timer2 (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_rd_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic count_gate_input_i,
  input wire logic ext_trigger_input_i,
  input wire logic reload_chan_capture_pin_i,
  input wire logic chan1_capture_pin_i,
  input wire logic chan2_capture_pin_i,
  input wire logic chan3_capture_pin_i,
  input wire logic ext_trigger_enable_i,
  input wire logic overflow_clr_i,
  input wire logic ext_trigger_clr_i,
  input wire logic [3:0] compare_irq_clr_i,
  input wire logic [3:0] port_latch_wr_i,
  input wire logic [3:0] port_latch_data_i,
  output logic overflow_flag_o,
  output logic ext_trigger_flag_o,
  output logic timer_irq_req_o,
  output logic [3:0] compare_interrupt_flag_o,
  output logic [3:0] compare_output_pin_o,
  output logic [3:0] compare_level_o
);
  import t2c_pkg::*;

  // ****************************************
  // Address decode
  // ****************************************
  // Channel 0 is the reload channel, 1 to 3 are the ordinary ones
  function automatic logic [7:0] chan_lo_addr(input int idx);
    case (idx)
      0: chan_lo_addr = `T2C_ADDR_RL_LO;
      1: chan_lo_addr = `T2C_ADDR_CH1_LO;
      2: chan_lo_addr = `T2C_ADDR_CH2_LO;
      default: chan_lo_addr = `T2C_ADDR_CH3_LO;
    endcase
  endfunction

  function automatic logic [7:0] chan_hi_addr(input int idx);
    case (idx)
      0: chan_hi_addr = `T2C_ADDR_RL_HI;
      1: chan_hi_addr = `T2C_ADDR_CH1_HI;
      2: chan_hi_addr = `T2C_ADDR_CH2_HI;
      default: chan_hi_addr = `T2C_ADDR_CH3_HI;
    endcase
  endfunction

  wire wr_ctrl = sfr_wr_i && (sfr_addr_i == `T2C_ADDR_CTRL);
  wire wr_mode = sfr_wr_i && (sfr_addr_i == `T2C_ADDR_MODE_EN);
  wire wr_cnt_lo = sfr_wr_i && (sfr_addr_i == `T2C_ADDR_CNT_LO);
  wire wr_cnt_hi = sfr_wr_i && (sfr_addr_i == `T2C_ADDR_CNT_HI);

  // ****************************************
  // Control registers
  // ****************************************
  logic [7:0] ctrl_q;
  logic [7:0] mode_en_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= `T2C_RST_BYTE;
      mode_en_q <= `T2C_RST_BYTE;
    end else begin
      if (wr_ctrl) ctrl_q <= sfr_wdata_i;
      if (wr_mode) mode_en_q <= sfr_wdata_i;
    end
  end

  wire prescale_select = ctrl_q[`T2C_BIT_PRESCALE];
  wire master_divide_select = ctrl_q[`T2C_BIT_MASTER_DIV];
  wire data_width_select = ctrl_q[`T2C_BIT_WIDTH];
  wire reload_mode_hi = ctrl_q[`T2C_BIT_RELOAD_HI];
  wire reload_mode_lo = ctrl_q[`T2C_BIT_RELOAD_LO];
  wire compare_mode_select = ctrl_q[`T2C_BIT_CMP_MODE];
  wire [1:0] input_select = {ctrl_q[`T2C_BIT_INSEL_HI],
    ctrl_q[`T2C_BIT_INSEL_LO]};
  wire t2c_insel_e insel = t2c_insel_e'(input_select);
  wire reload_on_ovf = reload_mode_hi && !reload_mode_lo;
  wire reload_on_trig = reload_mode_hi && reload_mode_lo;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Bits: 0 gate/event, 1 trigger, 2..5 capture pins of channels 0..3
  logic [5:0] meta_q;
  logic [5:0] sync_q;
  logic [5:0] prev_q;
  wire [5:0] pins_raw = {chan3_capture_pin_i, chan2_capture_pin_i,
    chan1_capture_pin_i, reload_chan_capture_pin_i,
    ext_trigger_input_i, count_gate_input_i};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= 6'h00;
      sync_q <= 6'h00;
      prev_q <= 6'h00;
    end else begin
      meta_q <= pins_raw;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  wire [5:0] fall = prev_q & ~sync_q;
  wire [5:0] rise = ~prev_q & sync_q;
  wire gate_level = sync_q[0];
  wire trig_fall = fall[1];

  // ****************************************
  // Prescaler
  // ****************************************
  logic [4:0] pre_cnt_q;
  wire [4:0] div_n = master_divide_select ? `T2C_DIV_MASTER :
    (prescale_select ? `T2C_DIV_SLOWER : `T2C_DIV_SLOW);
  wire tick = (pre_cnt_q >= div_n - 5'd1);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_cnt_q <= 5'd0;
    end else if (tick) begin
      pre_cnt_q <= 5'd0;
    end else begin
      pre_cnt_q <= pre_cnt_q + 5'd1;
    end
  end

  // ****************************************
  // Count source
  // ****************************************
  // The edge is registered so the step lands one cycle after detection
  logic event_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      event_q <= 1'b0;
    end else begin
      event_q <= fall[0];
    end
  end

  logic inc;

  always_comb begin
    case (insel)
      IN_STOP: inc = 1'b0;
      IN_INTERNAL: inc = tick;
      IN_EVENT: inc = event_q;
      IN_GATED: inc = tick && gate_level;
      default: inc = 1'b0;
    endcase
  end

  // ****************************************
  // Timer register
  // ****************************************
  logic [15:0] timer_q;
  logic [15:0] timer_d;
  logic [15:0] val_q [4];
  wire overflow = inc && (timer_q == 16'hffff);
  wire [15:0] reload_value = val_q[0];

  always_comb begin
    timer_d = timer_q;
    if (inc) timer_d = timer_q + 16'h0001;
    if (overflow && reload_on_ovf) timer_d = reload_value;
    if (trig_fall && reload_on_trig) timer_d = reload_value;
    // Software writes win so a preset is never lost to a step
    if (wr_cnt_lo) timer_d[7:0] = sfr_wdata_i;
    if (wr_cnt_hi) timer_d[15:8] = sfr_wdata_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_q <= `T2C_RST_WORD;
    end else begin
      timer_q <= timer_d;
    end
  end

  // ****************************************
  // Flags
  // ****************************************
  logic ovf_flag_q;
  logic trig_flag_q;
  logic [3:0] cmp_flag_q;
  logic [3:0] match;
  wire trig_set = trig_fall && ext_trigger_enable_i;

  // Set wins over a clear arriving in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ovf_flag_q <= 1'b0;
      trig_flag_q <= 1'b0;
      cmp_flag_q <= 4'h0;
    end else begin
      ovf_flag_q <= overflow || (ovf_flag_q && !overflow_clr_i);
      trig_flag_q <= trig_set || (trig_flag_q && !ext_trigger_clr_i);
      cmp_flag_q <= match | (cmp_flag_q & ~compare_irq_clr_i);
    end
  end

  // ****************************************
  // Channels
  // ****************************************
  // Ordinary pin captures sit one more cycle behind the reload channel
  logic [3:0] cap_dly_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cap_dly_q <= 4'h0;
    end else begin
      cap_dly_q <= {rise[5:3], 1'b0};
    end
  end

  wire [3:0] cap_evt = {cap_dly_q[3:1], fall[2]};

  for (genvar g = 0; g < 4; g++) begin : g_ch
    wire lo_hit = sfr_wr_i && (sfr_addr_i == chan_lo_addr(g));
    wire hi_hit = sfr_wr_i && (sfr_addr_i == chan_hi_addr(g));
    wire t2c_chmode_e mode = t2c_chmode_e'(mode_en_q[2*g+1:2*g]);
    wire cap_pin = (mode == CH_CAP_PIN) && cap_evt[g];
    wire cap_wr = (mode == CH_CAP_WRITE) && lo_hit;
    logic [15:0] val_d;

    always_comb begin
      val_d = val_q[g];
      if (cap_pin || cap_wr) begin
        val_d[7:0] = timer_q[7:0];
        // Narrow paths carry only the low byte
        if (!data_width_select) val_d[15:8] = timer_q[15:8];
      end else begin
        if (lo_hit) val_d[7:0] = sfr_wdata_i;
        if (hi_hit) val_d[15:8] = sfr_wdata_i;
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        val_q[g] <= `T2C_RST_WORD;
      end else begin
        val_q[g] <= val_d;
      end
    end

    t2c_ch_if chif ();
    assign chif.timer = timer_q;
    assign chif.value = val_q[g];
    assign chif.mode = mode;
    assign chif.cmp_mode = compare_mode_select;
    assign chif.narrow = data_width_select;
    assign chif.overflow = overflow;
    assign chif.latch_wr = port_latch_wr_i[g];
    assign chif.latch_d = port_latch_data_i[g];
    assign match[g] = chif.match;
    assign compare_output_pin_o[g] = chif.pin;
    assign compare_level_o[g] = chif.level;

    t2c_channel u_chan (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ch(chif.chan)
    );
  end

  // ****************************************
  // Register read port
  // ****************************************
  // One-cycle read latency; unmapped addresses read zero
  logic [7:0] rd_mux;
  logic [7:0] rdata_q;

  always_comb begin
    case (sfr_addr_i)
      `T2C_ADDR_CH1_LO: rd_mux = val_q[1][7:0];
      `T2C_ADDR_CH1_HI: rd_mux = val_q[1][15:8];
      `T2C_ADDR_CH2_LO: rd_mux = val_q[2][7:0];
      `T2C_ADDR_CH2_HI: rd_mux = val_q[2][15:8];
      `T2C_ADDR_CH3_LO: rd_mux = val_q[3][7:0];
      `T2C_ADDR_CH3_HI: rd_mux = val_q[3][15:8];
      `T2C_ADDR_CTRL: rd_mux = ctrl_q;
      `T2C_ADDR_MODE_EN: rd_mux = mode_en_q;
      `T2C_ADDR_RL_LO: rd_mux = val_q[0][7:0];
      `T2C_ADDR_RL_HI: rd_mux = val_q[0][15:8];
      `T2C_ADDR_CNT_LO: rd_mux = timer_q[7:0];
      `T2C_ADDR_CNT_HI: rd_mux = timer_q[15:8];
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= 8'h00;
    end else if (sfr_rd_i) begin
      rdata_q <= rd_mux;
    end
  end

  assign sfr_rdata_o = rdata_q;
  assign overflow_flag_o = ovf_flag_q;
  assign ext_trigger_flag_o = trig_flag_q;
  assign timer_irq_req_o = ovf_flag_q || trig_flag_q;
  assign compare_interrupt_flag_o = cmp_flag_q;
endmodule
`default_nettype wire

/* sim/t2c_pins_model.sv */
// Pin model: event/gate, trigger and capture pins of timer 2.
// Assumes the design samples these pins asynchronously.
`timescale 1ns/1ps
`default_nettype none
module t2c_pins_model (
  input wire logic clk_i,
  output logic [5:0] pin_o
);
  // ****************************************
  // Idle: gate, trigger, reload capture high
  // ****************************************
  initial pin_o = 6'h07;

  task automatic set_pin(input int i, input logic x);
    pin_o[i] = x;
    @(posedge clk_i);
    #1;
  endtask

  // Width w gives a prompt or a slow pulse
  task automatic pulse(input int i, input int w);
    pin_o[i] = ~pin_o[i];
    repeat (w) @(posedge clk_i);
    #1 pin_o[i] = ~pin_o[i];
    repeat (w) @(posedge clk_i);
    #1;
  endtask
endmodule
`default_nettype wire

/* sim/t2c_timer2_chk.sv */
// Port checks for timer 2: flags, read port and compare outputs.
// Assumes it is bound to t2c_timer2 and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module t2c_timer2_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic ext_trigger_enable_i,
  input wire logic overflow_clr_i,
  input wire logic ext_trigger_clr_i,
  input wire logic [3:0] compare_irq_clr_i,
  input wire logic overflow_flag_o,
  input wire logic ext_trigger_flag_o,
  input wire logic timer_irq_req_o,
  input wire logic [3:0] compare_interrupt_flag_o,
  input wire logic [3:0] compare_output_pin_o,
  input wire logic [3:0] compare_level_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ****************************************
  // Flags and outputs
  // ****************************************
  a_irq_is_or: assert property (
    timer_irq_req_o == (overflow_flag_o | ext_trigger_flag_o))
    else $error("irq request not the or of flags");
  a_ovf_held: assert property (
    $fell(overflow_flag_o) |-> $past(overflow_clr_i))
    else $error("overflow flag dropped without clear");
  a_ext_held: assert property (
    ext_trigger_flag_o && !ext_trigger_clr_i |=> ext_trigger_flag_o)
    else $error("trigger flag dropped without clear");
  a_ext_needs_en: assert property (
    $rose(ext_trigger_flag_o) |-> $past(ext_trigger_enable_i))
    else $error("trigger flag set while disabled");
  a_cmp_flag_held: assert property (
    1 |=> (($past(compare_interrupt_flag_o) & ~$past(compare_irq_clr_i)
      & ~compare_interrupt_flag_o) == 4'h0))
    else $error("compare flag dropped without clear");
  a_match_level_low: assert property (
    (compare_interrupt_flag_o & ~$past(compare_interrupt_flag_o)
      & compare_level_o) == 4'h0)
    else $error("compare level high at match");
  a_rdata_holds: assert property (
    !sfr_rd_i |=> $stable(sfr_rdata_o))
    else $error("read data changed without read");
  a_unmapped_zero: assert property (
    sfr_rd_i && (sfr_addr_i < 8'hc2 || sfr_addr_i > 8'hcd)
      |=> sfr_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_reset_quiet: assert property (
    $fell(rst_i) |-> {overflow_flag_o, ext_trigger_flag_o,
      compare_interrupt_flag_o, compare_output_pin_o} == 10'h000)
    else $error("outputs not cleared by reset");
endmodule
bind t2c_timer2 t2c_timer2_chk t2c_timer2_chk_i (.clk_i(clk_i),
  .rst_i(rst_i), .sfr_addr_i(sfr_addr_i), .sfr_rd_i(sfr_rd_i),
  .sfr_rdata_o(sfr_rdata_o), .ext_trigger_enable_i(ext_trigger_enable_i),
  .overflow_clr_i(overflow_clr_i), .ext_trigger_clr_i(ext_trigger_clr_i),
  .compare_irq_clr_i(compare_irq_clr_i), .overflow_flag_o(overflow_flag_o),
  .ext_trigger_flag_o(ext_trigger_flag_o),
  .timer_irq_req_o(timer_irq_req_o),
  .compare_interrupt_flag_o(compare_interrupt_flag_o),
  .compare_output_pin_o(compare_output_pin_o),
  .compare_level_o(compare_level_o));
`default_nettype wire

/* sim/test_timer2_compare_capture_reload.sv */
// Bench for timer 2: register tasks, pin model and scenarios.
// Assumes design, pin model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_timer2_compare_capture_reload;
  logic clk_i;
  logic rst_i = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic en_x = 1'b0;
  logic ovf_clr = 1'b0;
  logic ext_clr = 1'b0;
  logic [3:0] cmp_clr = 4'h0;
  logic [3:0] lat_wr = 4'h0;
  logic [3:0] lat_d = 4'h0;
  logic [7:0] rdata, d0, d1;
  logic ovf, ext, irq;
  logic [3:0] cflag, cpin, clev;
  logic [5:0] pins;
  logic [15:0] fl, outs;
  logic [7:0] cap_lo [4] = '{8'hca, 8'hc2, 8'hc4, 8'hc6};
  int errors = 0;
  int n_checks = 0;
  int cycles = 0;
  assign fl = {13'h0, ovf, ext, irq};
  assign outs = {4'h0, cpin, cflag, clev};

  t2c_timer2 t2c_timer2_i (.clk_i(clk_i), .rst_i(rst_i), .sfr_addr_i(addr),
    .sfr_wr_i(wr), .sfr_wdata_i(wdata), .sfr_rd_i(rd), .sfr_rdata_o(rdata),
    .count_gate_input_i(pins[0]), .ext_trigger_input_i(pins[1]),
    .reload_chan_capture_pin_i(pins[2]), .chan1_capture_pin_i(pins[3]),
    .chan2_capture_pin_i(pins[4]), .chan3_capture_pin_i(pins[5]),
    .ext_trigger_enable_i(en_x), .overflow_clr_i(ovf_clr),
    .ext_trigger_clr_i(ext_clr), .compare_irq_clr_i(cmp_clr),
    .port_latch_wr_i(lat_wr), .port_latch_data_i(lat_d),
    .overflow_flag_o(ovf), .ext_trigger_flag_o(ext), .timer_irq_req_o(irq),
    .compare_interrupt_flag_o(cflag), .compare_output_pin_o(cpin),
    .compare_level_o(clev));
  t2c_pins_model t2c_pins_model_i (.clk_i(clk_i), .pin_o(pins));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // ****************************************
  // Port tasks
  // ****************************************
  task step;
    @(posedge clk_i);
    #1;
  endtask
  task wreg(input logic [7:0] a, input logic [7:0] x);
    addr = a;
    wdata = x;
    wr = 1'b1;
    step();
    wr = 1'b0;
    step();
  endtask
  task rreg(input logic [7:0] a, output logic [7:0] x);
    addr = a;
    rd = 1'b1;
    step();
    rd = 1'b0;
    x = rdata;
    step();
  endtask
  task w16(input logic [7:0] a, input logic [15:0] x);
    wreg(a, x[7:0]);
    wreg(a + 8'h01, x[15:8]);
  endtask
  task chk(input string nm, input logic [15:0] x, input logic [15:0] y);
    n_checks++;
    if (y !== x) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, x, y);
    end
  endtask
  task chk16(input string nm, input logic [7:0] a, input logic [15:0] x);
    rreg(a, d0);
    rreg(a + 8'h01, d1);
    chk(nm, x, {d1, d0});
  endtask
  // Counts are compared over a span that every divisor splits evenly
  task rate(input logic [7:0] c, input logic [7:0] x);
    wreg(8'hc8, c);
    repeat (4) step();
    rreg(8'hcc, d0);
    repeat (46) step();
    rreg(8'hcc, d1);
    chk("rate", {8'h00, x}, {8'h00, d1 - d0});
  endtask
  task ev(input int n);
    repeat (n) t2c_pins_model_i.pulse(0, 4);
  endtask
  task clr_flags;
    ovf_clr = 1'b1;
    ext_clr = 1'b1;
    cmp_clr = 4'hf;
    step();
    ovf_clr = 1'b0;
    ext_clr = 1'b0;
    cmp_clr = 4'h0;
    step();
  endtask
  task latch(input logic [3:0] x);
    lat_d = x;
    lat_wr = 4'h2;
    step();
    lat_wr = 4'h0;
    step();
  endtask
  task tally_and_finish;
    if (errors == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      errors++;
      tally_and_finish();
    end
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (4) @(posedge clk_i);
    #1 rst_i = 1'b0;
    for (logic [7:0] a = 8'hc2; a != 8'hce; a++) begin
      rreg(a, d0);
      chk("reset", 16'h0000, {8'h00, d0});
    end
    for (logic [7:0] a = 8'hc2; a != 8'hcc; a++) begin
      if (a != 8'hc8 && a != 8'hc9) begin
        wreg(a, ~a);
        rreg(a, d0);
        chk("readback", {8'h00, ~a}, {8'h00, d0});
      end
    end
    wreg(8'hc1, 8'h5a);
    rreg(8'hc1, d0);
    chk("unmapped", 16'h0000, {8'h00, d0});
    rate(8'h41, 8'd24);
    rate(8'h01, 8'd4);
    rate(8'h81, 8'd2);
    rate(8'h00, 8'd0);
    t2c_pins_model_i.set_pin(0, 1'b0);
    rate(8'h43, 8'd0);
    t2c_pins_model_i.set_pin(0, 1'b1);
    rate(8'h43, 8'd24);
    wreg(8'hc8, 8'h00);
    clr_flags();
    w16(8'hcc, 16'h0000);
    wreg(8'hc8, 8'h02);
    ev(3);
    chk16("events", 8'hcc, 16'h0003);
    w16(8'hcc, 16'hffff);
    wreg(8'hc8, 8'h0a);
    ev(1);
    chk16("no reload", 8'hcc, 16'h0000);
    w16(8'hc2, 16'haaaa);
    w16(8'hca, 16'h1234);
    w16(8'hcc, 16'hffff);
    wreg(8'hc8, 8'h12);
    clr_flags();
    ev(1);
    chk16("reload0", 8'hcc, 16'h1234);
    chk("ovf flags", 16'h0005, fl);
    clr_flags();
    wreg(8'hc8, 8'h18);
    w16(8'hcc, 16'h0077);
    en_x = 1'b1;
    t2c_pins_model_i.pulse(1, 4);
    chk16("reload1", 8'hcc, 16'h1234);
    chk("trig flags", 16'h0003, fl);
    clr_flags();
    en_x = 1'b0;
    w16(8'hcc, 16'h0077);
    t2c_pins_model_i.pulse(1, 2);
    chk16("reload1 off", 8'hcc, 16'h1234);
    chk("trig off", 16'h0000, fl);
    wreg(8'hc8, 8'h00);
    w16(8'hcc, 16'h4321);
    wreg(8'hc9, 8'hff);
    for (int i = 0; i < 4; i++) begin
      wreg(cap_lo[i], 8'h00);
      chk16("wcap", cap_lo[i], 16'h4321);
    end
    w16(8'hcc, 16'h5a6b);
    wreg(8'hc9, 8'h55);
    for (int i = 0; i < 4; i++) begin
      t2c_pins_model_i.pulse(i + 2, 4);
      chk16("pcap", cap_lo[i], 16'h5a6b);
    end
    w16(8'hcc, 16'h0000);
    w16(8'hc2, 16'h0005);
    wreg(8'hc9, 8'h08);
    wreg(8'hc8, 8'h02);
    chk("cmp idle", 16'h0002, outs);
    ev(4);
    chk("cmp before", 16'h0002, outs);
    ev(1);
    chk("cmp match", 16'h0220, outs);
    latch(4'h0);
    chk("cmp latch", 16'h0220, outs);
    w16(8'hcc, 16'hffff);
    ev(1);
    chk("cmp ovf", 16'h0022, outs);
    clr_flags();
    wreg(8'hc8, 8'h06);
    latch(4'h2);
    chk("mode1 held", 16'h0002, outs);
    ev(5);
    chk("mode1 match", 16'h0220, outs);
    clr_flags();
    w16(8'hcc, 16'h0000);
    w16(8'hc4, 16'h7703);
    wreg(8'hc9, 8'h20);
    wreg(8'hc8, 8'h22);
    ev(3);
    chk("narrow", 16'h0004, {12'h000, cflag});
    chk("narrow pin", 16'h0006, {12'h000, cpin});
    latch(4'h0);
    chk("latch off", 16'h0004, {12'h000, cpin});
    tally_and_finish();
  end
endmodule
`default_nettype wire
